// File: bench/srt_net_node.sv
module srt_net_node (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         p_upd,
  input  wire         t_upd,
  input  wire  [31:0] p_val,
  input  wire  [31:0] p_real,
  output logic [15:0] p_cnt_r,
  output logic [15:0] t_cnt_r,
  output logic        pair_ok_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bench feeds the float as the integer inverted
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_cnt_r <= 16'h0;
      t_cnt_r <= 16'h0;
      pair_ok_r <= 1'b1;
    end else begin
      p_cnt_r <= p_cnt_r + {15'h0, p_upd};
      t_cnt_r <= t_cnt_r + {15'h0, t_upd};
      if (p_upd && p_real !== ~p_val) pair_ok_r <= 1'b0;
    end
  end
endmodule

// File: bench/srt_report_bench.sv
`include "srt_defines.vh"
module srt_report_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pressure_sample_valid = 1'b1, temperature_sample_valid = 1'b1;
  logic        bleed_sensor_present = 1'b0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, pressure_sample = 32'h0, pressure_real_sample = 32'hffffffff, q;
  logic [15:0] temperature_sample = 16'h0;
  logic [31:0] q0;
  wire  [31:0] prdata, pressure_scaled_out, pressure_real_out;
  wire  [15:0] temperature_out, p_cnt, t_cnt;
  wire         pready, pslverr, pressure_out_valid, pressure_update, temperature_update, pair_ok;
  int          fail_count = 0;
  int          checks_done = 0;

  srt_report #(.TICK_CYCLES(32'h4)) srt_report_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pressure_sample, .pressure_real_sample, .pressure_sample_valid, .temperature_sample,
    .temperature_sample_valid, .bleed_sensor_present, .pressure_scaled_out, .pressure_real_out,
    .pressure_out_valid, .pressure_update, .temperature_out, .temperature_update
  );
  srt_net_node srt_net_node_inst (
    .pclk, .presetn, .p_upd(pressure_update), .t_upd(temperature_update),
    .p_val(pressure_scaled_out), .p_real(pressure_real_out), .p_cnt_r(p_cnt),
    .t_cnt_r(t_cnt), .pair_ok_r(pair_ok)
  );

  always #2 pclk = ~pclk;
  // Ramps change every cycle so change triggers stay busy
  always @(posedge pclk) begin
    pressure_sample <= pressure_sample + 32'h1;
    pressure_real_sample <= ~(pressure_sample + 32'h1);
    temperature_sample <= temperature_sample + 16'h1;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task tmo;
    fail_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    wrap_up();
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) tmo();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task next_upd(input logic sel, output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((sel ? temperature_update : pressure_update) !== 1'b1 && n < 3000);
    if (n >= 3000) tmo();
  endtask
  // Program one measurement, then time the gap between two later sends
  task cfg(input logic sel, input logic [15:0] lng, sht, input logic [31:0] thr, input int lo, hi);
    logic [11:0] b;
    logic [31:0] dv;
    int          n;
    b = sel ? `SRT_OFF_T_LONG : `SRT_OFF_P_LONG;
    apb(1'b1, b, {16'h0, lng});
    apb(1'b1, b + 12'h4, {16'h0, sht});
    apb(1'b1, b + 12'h8, thr);
    next_upd(sel, n);
    dv = sel ? {16'h0, temperature_sample - temperature_out} : pressure_sample - pressure_scaled_out;
    chk(32'(dv >= 1 && dv <= 4), 32'h1);
    next_upd(sel, n);
    next_upd(sel, n);
    chk(32'(n >= lo && n <= hi), 32'h1);
    apb(1'b0, sel ? `SRT_OFF_T_ELAPSED : `SRT_OFF_P_ELAPSED, 32'h0);
    chk(32'(q <= 1), 32'h1);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SRT_OFF_CTRL, 32'h0);
    chk(q, `SRT_RST_CTRL);
    apb(1'b0, `SRT_OFF_P_THRESH, 32'h0);
    chk(q, `SRT_RST_THRESH);
    apb(1'b0, `SRT_OFF_T_THRESH, 32'h0);
    chk(q, `SRT_RST_THRESH);
    apb(1'b1, 12'h040, 32'h1);
    chk(32'(e), 32'h1);
    apb(1'b0, 12'h040, 32'h0);
    chk(q, 32'h0);
    repeat (300) @(negedge pclk);
    chk(32'(t_cnt), 32'h0);
    apb(1'b1, `SRT_OFF_P_THRESH, 32'h0);
    repeat (300) @(negedge pclk);
    chk(32'(p_cnt), 32'h0);
    chk(32'(pressure_out_valid), 32'h0);
    @(posedge pclk);
    bleed_sensor_present <= 1'b1;
    cfg(1'b0, 16'h1, 16'h2, 32'h0, 77, 82);
    cfg(1'b0, 16'h3, 16'h0, 32'hffffffff, 117, 122);
    cfg(1'b0, 16'h0, 16'h0, 32'h5, 48, 53);
    cfg(1'b1, 16'h0, 16'h5, 32'h0, 17, 22);
    cfg(1'b1, 16'h2, 16'h0, 32'hffffffff, 77, 82);
    cfg(1'b1, 16'h0, 16'h0, 32'h1e, 2, 5);
    @(negedge pclk);
    chk(32'(pressure_out_valid), 32'h1);
    chk(32'(pair_ok), 32'h1);
    apb(1'b0, `SRT_OFF_STATUS, 32'h0);
    chk(q, 32'hf);
    // Cleared enable must freeze the temperature side's count
    apb(1'b1, `SRT_OFF_CTRL, 32'h0);
    repeat (50) @(negedge pclk);
    apb(1'b0, `SRT_OFF_T_COUNT, 32'h0);
    q0 = q;
    chk(q, {16'h0, t_cnt});
    repeat (100) @(negedge pclk);
    chk({16'h0, t_cnt}, q0);
    wrap_up();
  end
endmodule

// File: bench/srt_report_props.sv
`include "srt_defines.vh"
module srt_report_props #(
  parameter        PW          = 32,
  parameter        TW          = 16,
  parameter [31:0] TICK_CYCLES = 32'h4
) (
  input wire          pclk,
  input wire          presetn,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [11:0]   paddr,
  input wire [31:0]   pwdata,
  input wire          pready,
  input wire          pslverr,
  input wire          bleed_sensor_present,
  input wire [PW-1:0] pressure_scaled_out,
  input wire [31:0]   pressure_real_out,
  input wire          pressure_out_valid,
  input wire          pressure_update,
  input wire [TW-1:0] temperature_out,
  input wire          temperature_update
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [15:0] p_short_r, t_short_r;
  logic [15:0] p_short_d, t_short_d;
  logic [23:0] p_gap_r, t_gap_r;
  int          p_min, t_min;
  wire         wr_hit = psel && penable && pwrite;
  // Shadow of the shortest settings, cycles since each send
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_short_r <= 16'h0;
      t_short_r <= 16'h0;
      p_short_d <= 16'h0;
      t_short_d <= 16'h0;
      p_gap_r <= '1;
      t_gap_r <= '1;
    end else begin
      if (wr_hit && paddr == `SRT_OFF_P_SHORT) p_short_r <= pwdata[15:0];
      if (wr_hit && paddr == `SRT_OFF_T_SHORT) t_short_r <= pwdata[15:0];
      // Pulse reflects the setting seen one cycle earlier
      p_short_d <= p_short_r;
      t_short_d <= t_short_r;
      p_gap_r <= pressure_update ? 24'h1 : p_gap_r + {23'h0, ~&p_gap_r};
      t_gap_r <= temperature_update ? 24'h1 : t_gap_r + {23'h0, ~&t_gap_r};
    end
  end
  // One tick of slack: the tick phase at the send is unknown
  always_comb begin
    p_min = p_short_d[15] ? 0 : int'(p_short_d) * `SRT_UNIT_TENTH * int'(TICK_CYCLES);
    t_min = t_short_d[15] ? 0 : int'(t_short_d) * `SRT_UNIT_HUNDREDTH * int'(TICK_CYCLES);
  end
  a_p_spacing: assert property (
    pressure_update |-> int'(p_gap_r) + int'(TICK_CYCLES) > p_min)
    else $error("Pressure sent too soon");
  a_t_spacing: assert property (
    temperature_update |-> int'(t_gap_r) + int'(TICK_CYCLES) > t_min)
    else $error("Temperature sent too soon");
  a_absent_quiet: assert property (!bleed_sensor_present [*4] |-> !pressure_update)
    else $error("Pressure sent without sensor");
  a_absent_invalid: assert property (!bleed_sensor_present [*5] |-> !pressure_out_valid)
    else $error("Pressure valid without sensor");
  a_pair_hold: assert property (!pressure_update |->
    $stable(pressure_scaled_out) && $stable(pressure_real_out))
    else $error("Pressure forms moved apart from a send");
  a_temp_hold: assert property (!temperature_update |-> $stable(temperature_out))
    else $error("Temperature moved without a send");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("Error outside access phase");
  a_ready_high: assert property (pready)
    else $error("Ready low");
  c_p_send: cover property (pressure_update);
  c_t_send: cover property (temperature_update);
  c_refused: cover property (psel && penable && pslverr);
endmodule

bind srt_report srt_report_props #(.PW(PW), .TW(TW), .TICK_CYCLES(TICK_CYCLES)) srt_report_props_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .bleed_sensor_present, .pressure_scaled_out, .pressure_real_out, .pressure_out_valid,
  .pressure_update, .temperature_out, .temperature_update
);

// File: design/srt_defines.vh
`ifndef SRT_DEFINES_VH
`define SRT_DEFINES_VH

// Clock and timebase
`define SRT_CLK_PERIOD_NS    4
`define SRT_TICK_NS          10000000
`define SRT_TICK_CYCLES      (`SRT_TICK_NS / `SRT_CLK_PERIOD_NS)
// Interval units expressed in 0.01 s ticks
`define SRT_UNIT_TENTH       10
`define SRT_UNIT_HUNDREDTH   1
// Threshold scaling against sample resolution
`define SRT_P_SMUL           1
`define SRT_P_TMUL           10
`define SRT_T_SMUL           10
`define SRT_T_TMUL           1

// APB register byte offsets
`define SRT_OFF_CTRL         12'h000
`define SRT_OFF_P_LONG       12'h004
`define SRT_OFF_P_SHORT      12'h008
`define SRT_OFF_P_THRESH     12'h00c
`define SRT_OFF_T_LONG       12'h010
`define SRT_OFF_T_SHORT      12'h014
`define SRT_OFF_T_THRESH     12'h018
`define SRT_OFF_STATUS       12'h01c
`define SRT_OFF_P_ELAPSED    12'h020
`define SRT_OFF_T_ELAPSED    12'h024
`define SRT_OFF_P_COUNT      12'h028
`define SRT_OFF_T_COUNT      12'h02c

// Field positions
`define SRT_CTRL_ENABLE      0
`define SRT_STAT_PRESENT     0
`define SRT_STAT_ENABLED     1
`define SRT_STAT_P_SEEN      2
`define SRT_STAT_T_SEEN      3

// Reset values
`define SRT_RST_CTRL         32'h0000_0001
`define SRT_RST_LONG         16'h0000
`define SRT_RST_SHORT        16'h0000
`define SRT_RST_THRESH       32'h7fff_ffff

`endif

// File: design/srt_report.v
// Chosen here: the APB register port and the address map.
`include "srt_defines.vh"

module srt_report #(
  parameter        PW          = 32,
  parameter        TW          = 16,
  parameter [31:0] TICK_CYCLES = `SRT_TICK_CYCLES
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output reg           pslverr,
  input  wire [PW-1:0] pressure_sample,
  input  wire [31:0]   pressure_real_sample,
  input  wire          pressure_sample_valid,
  input  wire [TW-1:0] temperature_sample,
  input  wire          temperature_sample_valid,
  input  wire          bleed_sensor_present,
  output reg  [PW-1:0] pressure_scaled_out,
  output reg  [31:0]   pressure_real_out,
  output reg           pressure_out_valid,
  output reg           pressure_update,
  output reg  [TW-1:0] temperature_out,
  output reg           temperature_update
);

  // Timebase: one pulse every 0.01 s
  reg  [31:0] tick_cnt_r;
  reg         tick_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYCLES - 32'h1) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r     <= 1'b0;
    end
  end

  // Sensor-present pin is asynchronous
  reg present_meta_r;
  reg present_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present_meta_r <= 1'b0;
      present_r      <= 1'b0;
    end else begin
      present_meta_r <= bleed_sensor_present;
      present_r      <= present_meta_r;
    end
  end

  // Configuration registers and send counters
  reg  [31:0] ctrl_r;
  reg  [15:0] longest_send_interval_p_r;
  reg  [15:0] shortest_send_interval_p_r;
  reg  [31:0] pressure_change_threshold_r;
  reg  [15:0] longest_send_interval_t_r;
  reg  [15:0] shortest_send_interval_t_r;
  reg  [31:0] temperature_change_threshold_r;
  reg  [31:0] p_count_r;
  reg  [31:0] t_count_r;

  wire        enable = ctrl_r[`SRT_CTRL_ENABLE];
  wire        p_send;
  wire        t_send;
  wire [31:0] p_elapsed;
  wire [31:0] t_elapsed;
  wire        p_seen;
  wire        t_seen;

  // APB slave, zero wait states
  assign pready = 1'b1;
  wire wr_en = psel && penable && pwrite;
  // Read data latched in setup so it stands through access
  wire rd_setup = psel && !penable && !pwrite;

  reg addr_ok;
  always @* begin
    case (paddr)
      `SRT_OFF_CTRL,
      `SRT_OFF_P_LONG,
      `SRT_OFF_P_SHORT,
      `SRT_OFF_P_THRESH,
      `SRT_OFF_T_LONG,
      `SRT_OFF_T_SHORT,
      `SRT_OFF_T_THRESH,
      `SRT_OFF_STATUS,
      `SRT_OFF_P_ELAPSED,
      `SRT_OFF_T_ELAPSED,
      `SRT_OFF_P_COUNT,
      `SRT_OFF_T_COUNT: addr_ok = 1'b1;
      default:          addr_ok = 1'b0;
    endcase
  end

  always @* begin
    pslverr = psel && penable && !addr_ok;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r                         <= `SRT_RST_CTRL;
      longest_send_interval_p_r      <= `SRT_RST_LONG;
      shortest_send_interval_p_r     <= `SRT_RST_SHORT;
      longest_send_interval_t_r      <= `SRT_RST_LONG;
      shortest_send_interval_t_r     <= `SRT_RST_SHORT;
      pressure_change_threshold_r    <= `SRT_RST_THRESH;
      temperature_change_threshold_r <= `SRT_RST_THRESH;
    end else if (wr_en) begin
      case (paddr)
        `SRT_OFF_CTRL:     ctrl_r                         <= {31'h0, pwdata[0]};
        `SRT_OFF_P_LONG:   longest_send_interval_p_r      <= pwdata[15:0];
        `SRT_OFF_P_SHORT:  shortest_send_interval_p_r     <= pwdata[15:0];
        `SRT_OFF_P_THRESH: pressure_change_threshold_r    <= pwdata;
        `SRT_OFF_T_LONG:   longest_send_interval_t_r      <= pwdata[15:0];
        `SRT_OFF_T_SHORT:  shortest_send_interval_t_r     <= pwdata[15:0];
        `SRT_OFF_T_THRESH: temperature_change_threshold_r <= pwdata;
        default: ;
      endcase
    end
  end

  // Status word assembled from the field positions
  reg [31:0] status_word;
  always @* begin
    status_word                    = 32'h0;
    status_word[`SRT_STAT_PRESENT] = present_r;
    status_word[`SRT_STAT_ENABLED] = enable;
    status_word[`SRT_STAT_P_SEEN]  = p_seen;
    status_word[`SRT_STAT_T_SEEN]  = t_seen;
  end

  // Interval registers read back sign-extended
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      case (paddr)
        `SRT_OFF_CTRL:      prdata <= ctrl_r;
        `SRT_OFF_P_LONG:    prdata <= {{16{longest_send_interval_p_r[15]}},
                                       longest_send_interval_p_r};
        `SRT_OFF_P_SHORT:   prdata <= {{16{shortest_send_interval_p_r[15]}},
                                       shortest_send_interval_p_r};
        `SRT_OFF_P_THRESH:  prdata <= pressure_change_threshold_r;
        `SRT_OFF_T_LONG:    prdata <= {{16{longest_send_interval_t_r[15]}},
                                       longest_send_interval_t_r};
        `SRT_OFF_T_SHORT:   prdata <= {{16{shortest_send_interval_t_r[15]}},
                                       shortest_send_interval_t_r};
        `SRT_OFF_T_THRESH:  prdata <= temperature_change_threshold_r;
        `SRT_OFF_STATUS:    prdata <= status_word;
        `SRT_OFF_P_ELAPSED: prdata <= p_elapsed;
        `SRT_OFF_T_ELAPSED: prdata <= t_elapsed;
        `SRT_OFF_P_COUNT:   prdata <= p_count_r;
        `SRT_OFF_T_COUNT:   prdata <= t_count_r;
        default:            prdata <= 32'h0;
      endcase
    end
  end

  // Floating form follows the integer sample it was paired with
  reg [31:0]   p_real_hold_r;
  reg [PW-1:0] p_int_hold_r;
  reg [TW-1:0] t_int_hold_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_real_hold_r <= 32'h0;
      p_int_hold_r  <= {PW{1'b0}};
    end else if (pressure_sample_valid) begin
      p_real_hold_r <= pressure_real_sample;
      p_int_hold_r  <= pressure_sample;
    end
  end

  // Mirrors the throttle's stored reading, taken on the same strobe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_int_hold_r <= {TW{1'b0}};
    end else if (temperature_sample_valid) begin
      t_int_hold_r <= temperature_sample;
    end
  end

  // pressure throttled only while a sensor is present
  wire p_enable = enable && present_r;

  // pressure intervals in 0.1 s units
  srt_throttle #(
    .W          (PW),
    .LONG_UNIT  (`SRT_UNIT_TENTH),
    .SHORT_UNIT (`SRT_UNIT_TENTH),
    .SMUL       (`SRT_P_SMUL),
    .TMUL       (`SRT_P_TMUL)
  ) u_pressure (
    .pclk         (pclk),
    .presetn      (presetn),
    .tick         (tick_r),
    .enable       (p_enable),
    .sample       (pressure_sample),
    .sample_valid (pressure_sample_valid),
    .longest      (longest_send_interval_p_r),
    .shortest     (shortest_send_interval_p_r),
    .threshold    (pressure_change_threshold_r),
    .send         (p_send),
    .sent_value_r (),
    .elapsed_r    (p_elapsed),
    .seen_r       (p_seen)
  );

  // temperature shortest in 0.01 s units
  srt_throttle #(
    .W          (TW),
    .LONG_UNIT  (`SRT_UNIT_TENTH),
    .SHORT_UNIT (`SRT_UNIT_HUNDREDTH),
    .SMUL       (`SRT_T_SMUL),
    .TMUL       (`SRT_T_TMUL)
  ) u_temperature (
    .pclk         (pclk),
    .presetn      (presetn),
    .tick         (tick_r),
    .enable       (enable),
    .sample       (temperature_sample),
    .sample_valid (temperature_sample_valid),
    .longest      (longest_send_interval_t_r),
    .shortest     (shortest_send_interval_t_r),
    .threshold    (temperature_change_threshold_r),
    .send         (t_send),
    .sent_value_r (),
    .elapsed_r    (t_elapsed),
    .seen_r       (t_seen)
  );

  // Published values change only on a send
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pressure_scaled_out <= {PW{1'b0}};
      pressure_real_out   <= 32'h0;
      pressure_update     <= 1'b0;
      p_count_r           <= 32'h0;
    end else begin
      pressure_update <= p_send;
      if (p_send) begin
        pressure_scaled_out <= p_int_hold_r;
        pressure_real_out   <= p_real_hold_r;
        p_count_r           <= p_count_r + 32'h1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pressure_out_valid <= 1'b0;
    end else if (!present_r) begin
      pressure_out_valid <= 1'b0;
    end else if (p_send) begin
      pressure_out_valid <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temperature_out    <= {TW{1'b0}};
      temperature_update <= 1'b0;
      t_count_r          <= 32'h0;
    end else begin
      temperature_update <= t_send;
      if (t_send) begin
        temperature_out <= t_int_hold_r;
        t_count_r       <= t_count_r + 32'h1;
      end
    end
  end

endmodule

// File: design/srt_throttle.v
module srt_throttle #(
  parameter W          = 32,
  parameter LONG_UNIT  = 10,
  parameter SHORT_UNIT = 10,
  parameter SMUL       = 1,
  parameter TMUL       = 10
) (
  input  wire                pclk,
  input  wire                presetn,
  input  wire                tick,
  input  wire                enable,
  input  wire [W-1:0]        sample,
  input  wire                sample_valid,
  input  wire [15:0]         longest,
  input  wire [15:0]         shortest,
  input  wire [31:0]         threshold,
  output reg                 send,
  output reg  [W-1:0]        sent_value_r,
  output reg  [31:0]         elapsed_r,
  output reg                 seen_r
);

  localparam [31:0] LU = LONG_UNIT;
  localparam [31:0] SU = SHORT_UNIT;
  localparam [31:0] SM = SMUL;
  localparam [31:0] TM = TMUL;

  reg  [W-1:0] sample_r;
  reg  [W-1:0] sample_nxt;
  reg          seen_nxt;

  // Negative intervals behave as zero
  wire [31:0] long_mag  = longest[15] ? 32'h0 : {16'h0, longest};
  wire [31:0] short_mag = shortest[15] ? 32'h0 : {16'h0, shortest};
  wire [31:0] long_ticks  = long_mag * LU;
  wire [31:0] short_ticks = short_mag * SU;

  wire signed [39:0] cur_ext  = {{(40-W){sample_r[W-1]}}, sample_r};
  wire signed [39:0] sent_ext = {{(40-W){sent_value_r[W-1]}}, sent_value_r};
  wire signed [39:0] diff     = cur_ext - sent_ext;
  wire        [39:0] diff_mag = diff[39] ? (40'h0 - diff) : diff;
  wire        [55:0] diff_sc  = diff_mag * SM;
  wire        [47:0] thr_sc   = {16'h0, threshold} * TM;

  wire short_ok = (elapsed_r >= short_ticks);
  wire long_due = (long_ticks != 32'h0) && (elapsed_r >= long_ticks);
  // Negative threshold disables the change trigger
  wire delta_hit = !threshold[31] && (diff_sc >= {8'h0, thr_sc});

  always @* begin
    sample_nxt = sample_valid ? sample : sample_r;
    seen_nxt   = seen_r | sample_valid;
    send = enable && seen_r && short_ok && (long_due || delta_hit);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_r     <= {W{1'b0}};
      sent_value_r <= {W{1'b0}};
      elapsed_r    <= 32'h0;
      seen_r       <= 1'b0;
    end else begin
      sample_r <= sample_nxt;
      seen_r   <= seen_nxt;
      if (send) begin
        sent_value_r <= sample_r;
        elapsed_r    <= 32'h0;
      end else if (tick && elapsed_r != 32'hffff_ffff) begin
        elapsed_r <= elapsed_r + 32'h1;
      end
    end
  end

endmodule
